// ===== rtl/analog_mux_defines.svh
// Constants for the positive input select register of the analog input mux.
// Assumes inclusion by bare name from any file that needs them.
`ifndef ANALOG_MUX_DEFINES_SVH
`define ANALOG_MUX_DEFINES_SVH

`define POS_SEL_ADDR        8'hbb
`define POS_SEL_CODE_MSB    4
`define POS_SEL_CODE_LSB    0
`define POS_SEL_RESET_CODE  5'h1f
`define POS_SEL_UNUSED_READ 3'h0
`define POS_SEL_READ_IDLE   8'h00
`define POS_SEL_NONE_RESET  1'b1
`define POS_SEL_PORT1_BASE  5'h08
`define POS_SEL_TEMP_CODE   5'h10
`define POS_SEL_SUPPLY_CODE 5'h11
`define POS_SEL_PORT2_FIRST 5'h12
`define POS_SEL_PORT2_LAST  5'h15

`endif

// ===== rtl/analog_mux_pkg.sv
// Types shared by the positive input select logic.
// Assumes nothing of its surroundings.
package analog_mux_pkg;

  typedef logic [4:0] sel_code_t;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port1;
    logic [3:0] port2;
    logic       temp_sensor;
    logic       supply;
  } mux_route_t;

endpackage

// ===== rtl/mux_sel_if.sv
// Carrier between the select register and its route decoder.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface mux_sel_if;
  analog_mux_pkg::sel_code_t  code_nxt;
  logic                       port2_present;
  analog_mux_pkg::mux_route_t route;

  modport reg_end
  (
    output code_nxt,
    output port2_present,
    input  route
  );

  modport decode_end
  (
    input  code_nxt,
    input  port2_present,
    output route
  );
endinterface
`default_nettype wire

// ===== rtl/mux_route_decoder.sv
// Registered decode of the positive select code into one-hot mux switches.
// Assumes the code arrives as the register's next value, same clock.
`timescale 1ns/10ps
`default_nettype none
`include "analog_mux_defines.svh"
module mux_route_decoder
(
  input  wire logic    ref_clk,
  input  wire logic    reset_n,
  mux_sel_if.decode_end sel
);
  wire logic       hit_port0;
  wire logic       hit_port1;
  wire logic       hit_port2;
  wire logic [4:0] port2_index;
  analog_mux_pkg::mux_route_t route_nxt;
  analog_mux_pkg::mux_route_t route_r;

  assign hit_port0   = sel.code_nxt < `POS_SEL_PORT1_BASE;
  assign hit_port1   = sel.code_nxt[4:3] == 2'h1;
  // Absent pins on small variants must never be switched in
  assign hit_port2   = sel.port2_present && (sel.code_nxt >= `POS_SEL_PORT2_FIRST)
                       && (sel.code_nxt <= `POS_SEL_PORT2_LAST); // RQ3
  assign port2_index = 5'(sel.code_nxt - `POS_SEL_PORT2_FIRST);

  always_comb
  begin
    route_nxt             = '0; // RQ4
    route_nxt.port0       = hit_port0 ? 8'(8'h01 << sel.code_nxt[2:0]) : 8'h00; // RQ2
    route_nxt.port1       = hit_port1 ? 8'(8'h01 << sel.code_nxt[2:0]) : 8'h00; // RQ2
    route_nxt.port2       = hit_port2 ? 4'(4'h1 << port2_index[1:0]) : 4'h0; // RQ3
    route_nxt.temp_sensor = sel.code_nxt == `POS_SEL_TEMP_CODE; // RQ2
    route_nxt.supply      = sel.code_nxt == `POS_SEL_SUPPLY_CODE; // RQ2
  end

  // Reset state has every switch open, matching the reset code
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      route_r <= '0; // RQ4
    else
      route_r <= route_nxt; // RQ6
  end

  assign sel.route = route_r;
endmodule
`default_nettype wire

// ===== rtl/analog_mux_positive_select.sv
// Positive input select register of the analog input mux, in SFR space.
// Assumes a single-cycle SFR access port driven by the core on ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "analog_mux_defines.svh"
// Notes on behaviour
// RQ1: Register at 0xBB, decoded on every page.
// RQ2: Codes pick port 0, port 1, sensor, supply.
// RQ3: Port 2 codes work only where pins exist.
// RQ4: Other codes connect nothing; reset code 11111.
// RQ5: Upper three bits read zero, writes ignored.
// RQ6: Write reaches select on next clock edge.
module analog_mux_positive_select
#(
  parameter bit PORT2_PINS_PRESENT = 1'b1
)
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [3:0]  sfr_page,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output var  logic [7:0]  sfr_rdata,
  output var  logic [4:0]  positive_select_code,
  output var  logic [7:0]  mux_port0_sel,
  output var  logic [7:0]  mux_port1_sel,
  output var  logic [3:0]  mux_port2_sel,
  output var  logic        mux_temp_sensor_sel,
  output var  logic        mux_supply_sel,
  output var  logic        mux_none_sel
);
  mux_sel_if sel ();

  wire logic                      addr_hit;
  wire logic                      write_hit;
  wire logic                      read_hit;
  wire logic [7:0]                rdata_nxt;
  wire analog_mux_pkg::sel_code_t code_nxt;
  wire logic                      code_in_port2;
  wire logic                      code_past_port2;
  wire logic                      none_nxt;
  analog_mux_pkg::sel_code_t      code_r;
  logic [7:0]                     rdata_r;
  logic                           none_r;

  // Page number plays no part: sfr_page is left unread, register on every page
  assign addr_hit    = sfr_addr == `POS_SEL_ADDR; // RQ1
  assign write_hit   = sfr_wr && addr_hit;
  assign read_hit    = sfr_rd && addr_hit;
  // Only the low five bits are stored; bits 7:5 are dropped
  assign code_nxt    = write_hit ? sfr_wdata[`POS_SEL_CODE_MSB:`POS_SEL_CODE_LSB]
                                 : code_r; // RQ5
  assign rdata_nxt   = read_hit ? {`POS_SEL_UNUSED_READ, code_r} : `POS_SEL_READ_IDLE; // RQ5

  // Open-input flag decoded from the next code so it flips with the switches
  assign code_in_port2   = (code_nxt >= `POS_SEL_PORT2_FIRST)
                           && (code_nxt <= `POS_SEL_PORT2_LAST);
  assign code_past_port2 = code_nxt > `POS_SEL_PORT2_LAST; // RQ4
  // Small variants leave port 2 codes open as well
  assign none_nxt        = code_past_port2 || (code_in_port2 && !PORT2_PINS_PRESENT); // RQ3

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      code_r <= `POS_SEL_RESET_CODE; // RQ4
    else
      code_r <= code_nxt; // RQ6
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= `POS_SEL_READ_IDLE;
    else
      rdata_r <= rdata_nxt;
  end

  // Registered so the open flag never glitches while switches change
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      none_r <= `POS_SEL_NONE_RESET; // RQ4
    else
      none_r <= none_nxt; // RQ6
  end

  assign sel.code_nxt      = code_nxt;
  assign sel.port2_present = PORT2_PINS_PRESENT; // RQ3

  mux_route_decoder u_decoder
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .sel     (sel.decode_end)
  );

  // Decoder flops update on the same edge as code_r, so both agree
  always_comb
  begin
    sfr_rdata            = rdata_r;
    positive_select_code = code_r;
    mux_port0_sel        = sel.route.port0;
    mux_port1_sel        = sel.route.port1;
    mux_port2_sel        = sel.route.port2;
    mux_temp_sensor_sel  = sel.route.temp_sensor;
    mux_supply_sel       = sel.route.supply;
    mux_none_sel         = none_r; // RQ4
  end
endmodule
`default_nettype wire

// ===== verification/analog_mux_positive_select_props.sv
// Checker for the positive input select register.
// Assumes the default build with port 2 pins present.
`timescale 1ns/10ps
`default_nettype none
module analog_mux_positive_select_props
(
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [4:0] positive_select_code,
  input wire logic [3:0] mux_port2_sel,
  input wire logic       mux_temp_sensor_sel,
  input wire logic       mux_none_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_write_takes_code: assert property (sfr_wr && sfr_addr == 8'hbb |=>
    positive_select_code == $past(sfr_wdata[4:0])) else $error("write not taken");
  a_code_holds: assert property (!(sfr_wr && sfr_addr == 8'hbb) |=>
    $stable(positive_select_code)) else $error("code changed");
  a_read_gives_code: assert property (sfr_rd && sfr_addr == 8'hbb |=>
    sfr_rdata == {3'h0, $past(positive_select_code)}) else $error("bad read");
  a_upper_read_zero: assert property (sfr_rdata[7:5] == 3'h0)
    else $error("upper bits set");
  a_temp_route: assert property ((positive_select_code == 5'h10) == mux_temp_sensor_sel)
    else $error("sensor switch wrong");
  a_port2_route: assert property (positive_select_code == 5'h12 |-> mux_port2_sel == 4'h1)
    else $error("port 2 switch wrong");
  a_none_above: assert property (positive_select_code > 5'h15 |-> mux_none_sel)
    else $error("input connected");
  cover property (sfr_wr && sfr_addr == 8'hbb);
  cover property (sfr_rd && sfr_addr == 8'hbb);
  cover property (mux_port2_sel != 4'h0);
  cover property (sfr_wr && sfr_addr == 8'hbb && sfr_wdata[7:5] != 3'h0);
endmodule
bind analog_mux_positive_select analog_mux_positive_select_props u_props (.ref_clk(ref_clk),
  .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .positive_select_code(positive_select_code),
  .mux_port2_sel(mux_port2_sel), .mux_temp_sensor_sel(mux_temp_sensor_sel),
  .mux_none_sel(mux_none_sel));
`default_nettype wire

// ===== verification/test_analog_mux_positive_select.sv
// Bench for the positive input select register.
// Assumes the default build with port 2 pins present.
`timescale 1ns/10ps
`default_nettype none
module test_analog_mux_positive_select;
  logic       ref_clk = 0, reset_n = 0, wr = 0, rd = 0, tmp, sup, none;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, p0, p1;
  logic [3:0] page = 4'h0, p2;
  logic [4:0] code;
  int         n_fail = 0, n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  analog_mux_positive_select dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(addr),
    .sfr_page(page), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .positive_select_code(code), .mux_port0_sel(p0), .mux_port1_sel(p1), .mux_port2_sel(p2),
    .mux_temp_sensor_sel(tmp), .mux_supply_sel(sup), .mux_none_sel(none));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One strobe cycle; read data is settled when this returns
  task automatic acc(input logic w, input logic [7:0] a, d, input logic [3:0] pg);
    @(posedge ref_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    page <= pg;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic t_all_codes;
    logic [4:0] c;
    for (int i = 0; i < 32; i++)
    begin
      c = i[4:0];
      acc(1, 8'hbb, {3'h7, c}, 4'h0);
      chk({p0, p1, tmp, sup}, {(c < 8) ? 8'h01 << c[2:0] : 8'h00,
        (c[4:3] == 2'b01) ? 8'h01 << c[2:0] : 8'h00, c == 5'h10, c == 5'h11});
      chk({p2, none}, {(c > 5'h11 && c < 5'h16) ? 4'h1 << (c - 5'h12) : 4'h0, c > 5'h15});
      acc(0, 8'hbb, 8'h00, 4'h0);
      chk(rdata, {3'h0, c});
    end
  endtask
  task automatic t_addr_pages;
    acc(1, 8'hbb, 8'h03, 4'hf);
    chk(code, 5'h03);
    acc(1, 8'hba, 8'h05, 4'h0);
    chk(code, 5'h03);
    acc(0, 8'hba, 8'h00, 4'h7);
    chk(rdata, 8'h00);
    acc(0, 8'hbb, 8'h00, 4'h9);
    chk(rdata, 8'h03);
    @(posedge ref_clk);
    #1;
    chk(rdata, 8'h00);
  endtask
  task automatic t_mid_reset;
    acc(1, 8'hbb, 8'h08, 4'h2);
    chk({code, p1}, {5'h08, 8'h01});
    reset_n <= 1'b0;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk({code, p1, none}, {5'h1f, 8'h00, 1'b1});
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk({code, none}, {5'h1f, 1'b1});
    chk({p0, p1, p2, tmp, sup, rdata}, 30'h0);
    t_all_codes();
    t_addr_pages();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
